// file: logic/rmsp_top.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module rmsp_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] radio_state,
   input wire logic radio_reset_command,
   output logic [1:0] op_mode,
   output logic freq_corr_enable,
   output logic [7:0] synth_lock_time,
   output logic [15:0] data_rate,
   output logic [23:0] sync_pattern,
   output logic [4:0] sync_length,
   output logic [1:0] sync_tolerance,
   output logic [3:0] rx_baseband_analog_bw,
   output logic tx_frontend_enable_pin_o,
   output logic tx_frontend_enable_pin_oe,
   output logic rx_frontend_enable_pin_o,
   output logic rx_frontend_enable_pin_oe,
   output logic rf_port1_active,
   output logic rf_port2_active
);
   // ==========================================
   // Address map table
   localparam logic [11:0] CFG_ADDR [rmsp_pkg::NUM_CFG] = '{
      rmsp_pkg::IDX_TX_PREAMBLE_COUNT, rmsp_pkg::IDX_SYNC_PATTERN_LOW,
      rmsp_pkg::IDX_SYNC_PATTERN_MID, rmsp_pkg::IDX_SYNC_PATTERN_HIGH,
      rmsp_pkg::IDX_SYNC_MATCH_SETUP, rmsp_pkg::IDX_RADIO_MODE_SELECT,
      rmsp_pkg::IDX_TX_FREQ_DEVIATION, rmsp_pkg::IDX_DISCRIMINATOR_BW,
      rmsp_pkg::IDX_TX_SHAPING_FILTER, rmsp_pkg::IDX_DATA_RATE_UPPER,
      rmsp_pkg::IDX_DATA_RATE_LOWER, rmsp_pkg::IDX_PIN_FUNCTION_SETUP,
      rmsp_pkg::IDX_SYNTH_LOCK_TIMING, rmsp_pkg::IDX_DIGITAL_IF_FILTER,
      rmsp_pkg::IDX_POST_DEMOD_BW, rmsp_pkg::IDX_RX_FRONTEND_SETUP,
      rmsp_pkg::IDX_GAIN_LOCK_SETUP, rmsp_pkg::IDX_GAIN_CEILING,
      rmsp_pkg::IDX_GAIN_SETUP_TWO, rmsp_pkg::IDX_GAIN_SETUP_THREE,
      rmsp_pkg::IDX_GAIN_SETUP_FOUR, rmsp_pkg::IDX_GAIN_SETUP_SIX,
      rmsp_pkg::IDX_GAIN_SETUP_SEVEN, rmsp_pkg::IDX_OFFSET_LOOP_SETUP_A,
      rmsp_pkg::IDX_OFFSET_LOOP_SETUP_B, rmsp_pkg::IDX_OFFSET_LOOP_BW_ZERO,
      rmsp_pkg::IDX_OFFSET_LOOP_BW_ONE, rmsp_pkg::IDX_OFFSET_LOOP_BW_TWO,
      rmsp_pkg::IDX_OFFSET_LOOP_BW_THREE, rmsp_pkg::IDX_OFFSET_LOOP_BW_FOUR,
      rmsp_pkg::IDX_OFFSET_LOOP_BW_SELECT, rmsp_pkg::IDX_OFFSET_LOOP_BW_THIRTEEN,
      rmsp_pkg::IDX_PREAMBLE_CHECK_COUNT, rmsp_pkg::IDX_FREQ_CORR_SETUP,
      rmsp_pkg::IDX_FREQ_CORR_GAINS, rmsp_pkg::IDX_FREQ_CORR_SPAN};

   localparam int I_SYNC0 = 1;
   localparam int I_SYNC1 = 2;
   localparam int I_SYNC2 = 3;
   localparam int I_SYNC_SETUP = 4;
   localparam int I_MODE = 5;
   localparam int I_DR_HI = 9;
   localparam int I_DR_LO = 10;
   localparam int I_SYNTH = 12;
   localparam int I_RXFE = 15;
   localparam int I_PRE_CHECK = 32;
   localparam int I_FC_SETUP = 33;

   // ==========================================
   // State
   typedef struct packed {
      logic [rmsp_pkg::NUM_CFG-1:0][7:0] cfg;
      logic [1:0] fe_ctrl;
      logic [1:0] op_mode;
      logic [31:0] rdata;
   } rmsp_top_state_t;

   rmsp_top_state_t s_q;
   rmsp_top_state_t s_d;

   rmsp_fe_if fe_bus ();

   logic [11:0] word_idx;
   logic setup_hit;
   logic access_wr;

   assign word_idx = paddr[13:2];
   assign setup_hit = psel && !penable;
   assign access_wr = psel && penable && pwrite;

   always_comb begin
      s_d = s_q;
      // Read data is captured in the setup cycle so the access phase always ends in one cycle
      if (setup_hit) begin
         s_d.rdata = '0;
         if (word_idx == rmsp_pkg::IDX_FRONTEND_CTRL) begin
            s_d.rdata = {30'h0, s_q.fe_ctrl};
         end else if (word_idx == rmsp_pkg::IDX_RADIO_STATUS) begin
            s_d.rdata = {24'h0, rf_port2_active, rf_port1_active, s_q.op_mode, 2'h0, radio_state};
         end else begin
            for (int i = 0; i < rmsp_pkg::NUM_CFG; i++) begin
               if (word_idx == CFG_ADDR[i]) begin
                  s_d.rdata = {24'h0, s_q.cfg[i]};
               end
            end
         end
      end
      if (access_wr) begin
         if (word_idx == rmsp_pkg::IDX_FRONTEND_CTRL) begin
            s_d.fe_ctrl = pwdata[1:0];
         end else begin
            for (int i = 0; i < rmsp_pkg::NUM_CFG; i++) begin
               if (word_idx == CFG_ADDR[i]) begin
                  s_d.cfg[i] = pwdata[7:0];
               end
            end
         end
      end
      // Mode select writes of the packet or stream value take hold on the next clock; the radio reset command forces IEEE mode and wins
      if (radio_reset_command) begin
         s_d.op_mode = rmsp_pkg::RMSP_OP_IEEE;
      end else if (access_wr && word_idx == rmsp_pkg::IDX_RADIO_MODE_SELECT) begin
         if (pwdata[7:0] == rmsp_pkg::MODE_FSK_PACKET) begin
            s_d.op_mode = rmsp_pkg::RMSP_OP_FSK_PACKET;
         end else if (pwdata[7:0] == rmsp_pkg::MODE_FSK_STREAM) begin
            s_d.op_mode = rmsp_pkg::RMSP_OP_FSK_STREAM;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q.cfg <= '0;
         s_q.cfg[I_RXFE] <= rmsp_pkg::RX_FRONTEND_RESET;
         s_q.cfg[I_PRE_CHECK] <= rmsp_pkg::PREAMBLE_CHECK_RESET;
         s_q.fe_ctrl <= 2'h0;
         s_q.op_mode <= rmsp_pkg::RMSP_OP_IEEE;
         s_q.rdata <= 32'h0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================
   // APB answer: zero wait states, unmapped reads give zero
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = s_q.rdata;

   // ==========================================
   // Configuration outputs
   assign op_mode = s_q.op_mode;
   assign freq_corr_enable = (s_q.cfg[I_FC_SETUP] == rmsp_pkg::FREQ_CORR_ENABLE);
   assign synth_lock_time = s_q.cfg[I_SYNTH];
   assign data_rate = {s_q.cfg[I_DR_HI], s_q.cfg[I_DR_LO]};
   assign sync_pattern = {s_q.cfg[I_SYNC2], s_q.cfg[I_SYNC1], s_q.cfg[I_SYNC0]};
   assign sync_length = s_q.cfg[I_SYNC_SETUP][4:0];
   assign sync_tolerance = s_q.cfg[I_SYNC_SETUP][6:5];
   assign rx_baseband_analog_bw = s_q.cfg[I_RXFE][3:0];

   // ==========================================
   // Front end
   assign fe_bus.radio_state = radio_state;
   assign fe_bus.txen_en = s_q.fe_ctrl[rmsp_pkg::TXEN_EN_BIT];
   assign fe_bus.rxen_en = s_q.fe_ctrl[rmsp_pkg::RXEN_EN_BIT];
   assign fe_bus.lna_sel = s_q.cfg[I_RXFE][rmsp_pkg::LNA_SEL_LSB +: 3];

   rmsp_frontend u_fe (
      .clk(clk),
      .reset(reset),
      .fe(fe_bus.fe)
   );

   assign tx_frontend_enable_pin_o = fe_bus.tx_pin_o;
   assign tx_frontend_enable_pin_oe = fe_bus.tx_pin_oe;
   assign rx_frontend_enable_pin_o = fe_bus.rx_pin_o;
   assign rx_frontend_enable_pin_oe = fe_bus.rx_pin_oe;
   assign rf_port1_active = fe_bus.port1_active;
   assign rf_port2_active = fe_bus.port2_active;
endmodule // rmsp_top

// file: logic/rmsp_pkg.sv
package rmsp_pkg;
   // ==========================================
   // Register indices; offsets count 32-bit words, so the byte address is four times these
   localparam logic [11:0] IDX_TX_PREAMBLE_COUNT = 12'h102;
   localparam logic [11:0] IDX_SYNC_PATTERN_LOW = 12'h10c;
   localparam logic [11:0] IDX_SYNC_PATTERN_MID = 12'h10d;
   localparam logic [11:0] IDX_SYNC_PATTERN_HIGH = 12'h10e;
   localparam logic [11:0] IDX_SYNC_MATCH_SETUP = 12'h10f;
   localparam logic [11:0] IDX_RADIO_MODE_SELECT = 12'h13e;
   localparam logic [11:0] IDX_TX_FREQ_DEVIATION = 12'h304;
   localparam logic [11:0] IDX_DISCRIMINATOR_BW = 12'h305;
   localparam logic [11:0] IDX_TX_SHAPING_FILTER = 12'h306;
   localparam logic [11:0] IDX_DATA_RATE_UPPER = 12'h30e;
   localparam logic [11:0] IDX_DATA_RATE_LOWER = 12'h30f;
   localparam logic [11:0] IDX_PIN_FUNCTION_SETUP = 12'h32c;
   localparam logic [11:0] IDX_SYNTH_LOCK_TIMING = 12'h335;
   localparam logic [11:0] IDX_DIGITAL_IF_FILTER = 12'h389;
   localparam logic [11:0] IDX_POST_DEMOD_BW = 12'h38b;
   localparam logic [11:0] IDX_RX_FRONTEND_SETUP = 12'h39b;
   localparam logic [11:0] IDX_GAIN_LOCK_SETUP = 12'h3b2;
   localparam logic [11:0] IDX_GAIN_CEILING = 12'h3b4;
   localparam logic [11:0] IDX_GAIN_SETUP_TWO = 12'h3b6;
   localparam logic [11:0] IDX_GAIN_SETUP_THREE = 12'h3b7;
   localparam logic [11:0] IDX_GAIN_SETUP_FOUR = 12'h3b8;
   localparam logic [11:0] IDX_GAIN_SETUP_SIX = 12'h3ba;
   localparam logic [11:0] IDX_GAIN_SETUP_SEVEN = 12'h3bc;
   localparam logic [11:0] IDX_OFFSET_LOOP_SETUP_A = 12'h3bf;
   localparam logic [11:0] IDX_OFFSET_LOOP_SETUP_B = 12'h3c4;
   localparam logic [11:0] IDX_OFFSET_LOOP_BW_ZERO = 12'h3d2;
   localparam logic [11:0] IDX_OFFSET_LOOP_BW_ONE = 12'h3d3;
   localparam logic [11:0] IDX_OFFSET_LOOP_BW_TWO = 12'h3d4;
   localparam logic [11:0] IDX_OFFSET_LOOP_BW_THREE = 12'h3d5;
   localparam logic [11:0] IDX_OFFSET_LOOP_BW_FOUR = 12'h3d6;
   localparam logic [11:0] IDX_OFFSET_LOOP_BW_SELECT = 12'h3d7;
   localparam logic [11:0] IDX_OFFSET_LOOP_BW_THIRTEEN = 12'h3e0;
   localparam logic [11:0] IDX_PREAMBLE_CHECK_COUNT = 12'h3f3;
   localparam logic [11:0] IDX_FREQ_CORR_SETUP = 12'h3f7;
   localparam logic [11:0] IDX_FREQ_CORR_GAINS = 12'h3f8;
   localparam logic [11:0] IDX_FREQ_CORR_SPAN = 12'h3f9;
   // Own registers: front-end control and radio status
   localparam logic [11:0] IDX_FRONTEND_CTRL = 12'h400;
   localparam logic [11:0] IDX_RADIO_STATUS = 12'h401;
   localparam int NUM_CFG = 36;

   // ==========================================
   // Field positions and values
   localparam int LNA_SEL_LSB = 4;
   localparam logic [2:0] LNA_SEL_PORT1 = 3'h0;
   localparam logic [2:0] LNA_SEL_PORT2 = 3'h1;
   localparam logic [7:0] RX_FRONTEND_RESET = 8'h10;
   localparam logic [7:0] PREAMBLE_CHECK_RESET = 8'h05;
   localparam logic [7:0] MODE_FSK_PACKET = 8'h04;
   localparam logic [7:0] MODE_FSK_STREAM = 8'h03;
   localparam logic [7:0] FREQ_CORR_ENABLE = 8'h07;
   localparam int TXEN_EN_BIT = 0;
   localparam int RXEN_EN_BIT = 1;

   // ==========================================
   // Radio state supplied by the radio controller
   typedef enum logic [1:0] {
      RMSP_ST_SLEEP = 2'h0,
      RMSP_ST_IDLE = 2'h1,
      RMSP_ST_RX = 2'h2,
      RMSP_ST_TX = 2'h3
   } rmsp_radio_state_t;

   typedef enum logic [1:0] {
      RMSP_OP_IEEE = 2'h0,
      RMSP_OP_FSK_PACKET = 2'h1,
      RMSP_OP_FSK_STREAM = 2'h2
   } rmsp_op_mode_t;
endpackage

// file: logic/rmsp_fe_if.sv
`timescale 1ns/1ps
interface rmsp_fe_if;
   logic [1:0] radio_state;
   logic txen_en;
   logic rxen_en;
   logic [2:0] lna_sel;
   logic tx_pin_o;
   logic tx_pin_oe;
   logic rx_pin_o;
   logic rx_pin_oe;
   logic port1_active;
   logic port2_active;
   modport ctrl (output radio_state, txen_en, rxen_en, lna_sel,
      input tx_pin_o, tx_pin_oe, rx_pin_o, rx_pin_oe, port1_active, port2_active);
   modport fe (input radio_state, txen_en, rxen_en, lna_sel,
      output tx_pin_o, tx_pin_oe, rx_pin_o, rx_pin_oe, port1_active, port2_active);
endinterface

// file: logic/rmsp_frontend.sv
`timescale 1ns/1ps
module rmsp_frontend (
   input wire logic clk,
   input wire logic reset,
   rmsp_fe_if.fe fe
);
   typedef struct packed {
      logic tx_o;
      logic tx_oe;
      logic rx_o;
      logic rx_oe;
      logic p1;
      logic p2;
   } rmsp_fe_state_t;

   rmsp_fe_state_t s_q;
   rmsp_fe_state_t s_d;

   always_comb begin
      s_d = '0;
      // Sleep leaves both pins undriven; board pull-downs define the level
      if (fe.radio_state != rmsp_pkg::RMSP_ST_SLEEP) begin
         s_d.tx_oe = 1'b1;
         s_d.rx_oe = 1'b1;
      end
      s_d.tx_o = fe.txen_en && (fe.radio_state == rmsp_pkg::RMSP_ST_TX);
      s_d.rx_o = fe.rxen_en && (fe.radio_state == rmsp_pkg::RMSP_ST_RX);
      // Transmit always uses port 2; receive port follows the select field
      if (fe.radio_state == rmsp_pkg::RMSP_ST_TX) begin
         s_d.p2 = 1'b1;
      end else if (fe.radio_state == rmsp_pkg::RMSP_ST_RX) begin
         if (fe.lna_sel == rmsp_pkg::LNA_SEL_PORT1) begin
            s_d.p1 = 1'b1;
         end else begin
            s_d.p2 = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign fe.tx_pin_o = s_q.tx_o;
   assign fe.tx_pin_oe = s_q.tx_oe;
   assign fe.rx_pin_o = s_q.rx_o;
   assign fe.rx_pin_oe = s_q.rx_oe;
   assign fe.port1_active = s_q.p1;
   assign fe.port2_active = s_q.p2;
endmodule // rmsp_frontend

// file: sim/rmsp_props.sv
`timescale 1ns/1ps
module rmsp_props (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [1:0] radio_state,
   input wire logic radio_reset_command,
   input wire logic [1:0] op_mode,
   input wire logic freq_corr_enable,
   input wire logic tx_frontend_enable_pin_o,
   input wire logic tx_frontend_enable_pin_oe,
   input wire logic rx_frontend_enable_pin_o,
   input wire logic rx_frontend_enable_pin_oe,
   input wire logic rf_port1_active,
   input wire logic rf_port2_active
);
   // ==========================================
   // Shadow of front-end control and port select, rebuilt from bus writes
   logic [1:0] ctl_q;
   logic [2:0] lna_q;
   logic wr_go;
   logic [7:0] wr_low;
   assign wr_go = psel && penable && pwrite;
   assign wr_low = pwdata[7:0];
   always_ff @(posedge clk) begin
      if (reset) begin
         ctl_q <= 2'h0;
         lna_q <= rmsp_pkg::LNA_SEL_PORT2;
      end else if (wr_go && paddr == 14'h1000) begin
         ctl_q <= pwdata[1:0];
      end else if (wr_go && paddr == 14'h0e6c) begin
         lna_q <= pwdata[6:4];
      end
   end
   // ==========================================
   // Properties
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   sequence s_mode_wr(logic [7:0] v);
      wr_go && paddr == 14'h04f8 && wr_low == v && !radio_reset_command;
   endsequence
   sequence s_corr_wr;
      wr_go && paddr == 14'h0fdc;
   endsequence
   a_mode_packet: assert property (s_mode_wr(rmsp_pkg::MODE_FSK_PACKET) |=> op_mode == 2'h1)
      else $error("packet mode not taken");
   a_mode_stream: assert property (s_mode_wr(rmsp_pkg::MODE_FSK_STREAM) |=> op_mode == 2'h2)
      else $error("stream mode not taken");
   a_reset_cmd: assert property (radio_reset_command |=> op_mode == 2'h0)
      else $error("reset command ignored");
   a_corr_enable: assert property (s_corr_wr |=> freq_corr_enable == ($past(wr_low) == 8'h07))
      else $error("frequency correction enable wrong");
   a_tx_pin_follow: assert property (ctl_q[0] && radio_state != rmsp_pkg::RMSP_ST_SLEEP |=>
      tx_frontend_enable_pin_oe && tx_frontend_enable_pin_o == ($past(radio_state) == 2'h3))
      else $error("tx front-end pin wrong");
   a_rx_pin_follow: assert property (ctl_q[1] && radio_state != rmsp_pkg::RMSP_ST_SLEEP |=>
      rx_frontend_enable_pin_oe && rx_frontend_enable_pin_o == ($past(radio_state) == 2'h2))
      else $error("rx front-end pin wrong");
   a_sleep_float: assert property (radio_state == rmsp_pkg::RMSP_ST_SLEEP |=>
      !tx_frontend_enable_pin_oe && !rx_frontend_enable_pin_oe)
      else $error("front-end pin driven in sleep");
   a_fe_exclusive: assert property (!(tx_frontend_enable_pin_o && tx_frontend_enable_pin_oe &&
      rx_frontend_enable_pin_o && rx_frontend_enable_pin_oe))
      else $error("both front-end pins high");
   a_port_one: assert property (radio_state == 2'h2 && lna_q == 3'h0 |=>
      rf_port1_active && !rf_port2_active)
      else $error("receive not on port 1");
   a_port_two: assert property ((radio_state == 2'h3 || radio_state == 2'h2 && lna_q != 3'h0)
      |=> rf_port2_active && !rf_port1_active)
      else $error("port 2 not active");
   a_reset_dflt: assert property ($fell(reset) |-> op_mode == 2'h0 && !freq_corr_enable)
      else $error("reset defaults wrong");
endmodule // rmsp_props

// file: sim/rmsp_fe_model.sv
`timescale 1ns/1ps
// ==========================================
// External front end: pins carry pull-downs, so a released pin reads low
module rmsp_fe_model (
   input wire logic tx_o,
   input wire logic tx_oe,
   input wire logic rx_o,
   input wire logic rx_oe,
   output logic tx_level,
   output logic rx_level
);
   assign tx_level = tx_oe ? tx_o : 1'b0;
   assign rx_level = rx_oe ? rx_o : 1'b0;
endmodule // rmsp_fe_model

// file: sim/radio_mode_setup_and_port_select_tb_top.sv
`timescale 1ns/1ps
module radio_mode_setup_and_port_select_tb_top;
   logic clk, reset, psel, penable, pwrite, radio_reset_command, pready, pslverr, fc;
   logic txo, txoe, rxo, rxoe, p1, p2, tx_lvl, rx_lvl;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] radio_state, op_mode, stol;
   logic [7:0] slock;
   logic [15:0] drate;
   logic [23:0] spat;
   logic [4:0] slen;
   logic [3:0] bbw;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int i;
   // Host bring-up for 250 kbps packet mode: {offset, value}
   logic [19:0] cfg [35] = '{20'h33528, 20'h3b234, 20'h3b480, 20'h3b637, 20'h3b72a,
      20'h3b81d, 20'h3ba24, 20'h3bc7b, 20'h3bf00, 20'h3c407, 20'h3d21a, 20'h3d319, 20'h3d41e,
      20'h3d51e, 20'h3d61e, 20'h3d700, 20'h3e0f0, 20'h3f301, 20'h10205, 20'h3040d, 20'h30519,
      20'h30602, 20'h30e09, 20'h30fc4, 20'h38912, 20'h38b20, 20'h10c31, 20'h10d7f, 20'h10eaa,
      20'h10f10, 20'h3f707, 20'h3f899, 20'h3f950, 20'h39b16, 20'h13e04};
   rmsp_top uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .radio_state(radio_state), .radio_reset_command(radio_reset_command), .op_mode(op_mode),
      .freq_corr_enable(fc), .synth_lock_time(slock), .data_rate(drate), .sync_pattern(spat),
      .sync_length(slen), .sync_tolerance(stol), .rx_baseband_analog_bw(bbw),
      .tx_frontend_enable_pin_o(txo), .tx_frontend_enable_pin_oe(txoe),
      .rx_frontend_enable_pin_o(rxo), .rx_frontend_enable_pin_oe(rxoe),
      .rf_port1_active(p1), .rf_port2_active(p2));
   rmsp_fe_model fe (.tx_o(txo), .tx_oe(txoe), .rx_o(rxo), .rx_oe(rxoe),
      .tx_level(tx_lvl), .rx_level(rx_lvl));
   // ==========================================
   // Checking and bus tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic wr, input logic [11:0] off, input logic [7:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {off, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdc(input logic [11:0] off, input logic [31:0] exp);
      apb(1'b0, off, 8'h00);
      chk(rd, exp);
   endtask
   // Outputs move a clock after the cause; look mid-cycle after that
   task settle;
      @(posedge clk);
      @(negedge clk);
   endtask
   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================
   // Clock, timeout and test sequence
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         end_sim;
      end
   end
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 14'h0;
      pwdata = 32'h0;
      radio_state = 2'h0;
      radio_reset_command = 1'b0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rdc(rmsp_pkg::IDX_RX_FRONTEND_SETUP, 32'h10);
      rdc(rmsp_pkg::IDX_PREAMBLE_CHECK_COUNT, 32'h05);
      rdc(rmsp_pkg::IDX_RADIO_STATUS, 32'h0);
      chk({30'h0, pready, pslverr}, 32'h2);
      apb(1'b1, 12'h7ff, 8'h5a);
      rdc(12'h7ff, 32'h0);
      @(posedge clk);
      radio_reset_command <= 1'b1;
      @(posedge clk);
      radio_reset_command <= 1'b0;
      for (i = 0; i < 35; i++) apb(1'b1, cfg[i][19:8], cfg[i][7:0]);
      for (i = 0; i < 35; i++) rdc(cfg[i][19:8], {24'h0, cfg[i][7:0]});
      settle;
      chk({24'h0, slock}, 32'h28);
      chk({16'h0, drate}, 32'h09c4);
      chk({8'h0, spat}, 32'haa7f31);
      chk({25'h0, stol, slen}, 32'h10);
      chk({28'h0, bbw}, 32'h6);
      chk({29'h0, fc, op_mode}, 32'h5);
      apb(1'b1, rmsp_pkg::IDX_RADIO_MODE_SELECT, rmsp_pkg::MODE_FSK_STREAM);
      settle;
      chk({30'h0, op_mode}, 32'h2);
      apb(1'b1, rmsp_pkg::IDX_RADIO_MODE_SELECT, 8'h05);
      settle;
      chk({30'h0, op_mode}, 32'h2);
      @(posedge clk);
      radio_reset_command <= 1'b1;
      @(posedge clk);
      radio_reset_command <= 1'b0;
      settle;
      chk({30'h0, op_mode}, 32'h0);
      // Standard frame delimiter kept, so no extra delimiter write follows
      apb(1'b1, rmsp_pkg::IDX_TX_SHAPING_FILTER, 8'h01);
      rdc(rmsp_pkg::IDX_TX_SHAPING_FILTER, 32'h01);
      apb(1'b1, rmsp_pkg::IDX_FREQ_CORR_SETUP, 8'h00);
      settle;
      chk({31'h0, fc}, 32'h0);
      apb(1'b1, rmsp_pkg::IDX_FRONTEND_CTRL, 8'h03);
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         radio_state <= i[1:0];
         settle;
         chk({26'h0, txoe, tx_lvl, rxoe, rx_lvl, p1, p2},
            {26'h0, i != 0, i == 3, i != 0, i == 2, 1'b0, i >= 2});
         rdc(rmsp_pkg::IDX_RADIO_STATUS, {24'h0, i >= 2, 1'b0, 4'h0, i[1:0]});
      end
      // Port switch made outside any reception, so no received data is cut
      apb(1'b1, rmsp_pkg::IDX_RX_FRONTEND_SETUP, 8'h06);
      @(posedge clk);
      radio_state <= 2'h2;
      settle;
      chk({30'h0, p1, p2}, 32'h2);
      @(posedge clk);
      radio_state <= 2'h3;
      settle;
      chk({30'h0, p1, p2}, 32'h1);
      end_sim;
   end
endmodule // radio_mode_setup_and_port_select_tb_top

bind rmsp_top rmsp_props u_props (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .radio_state(radio_state),
   .radio_reset_command(radio_reset_command), .op_mode(op_mode),
   .freq_corr_enable(freq_corr_enable), .tx_frontend_enable_pin_o(tx_frontend_enable_pin_o),
   .tx_frontend_enable_pin_oe(tx_frontend_enable_pin_oe),
   .rx_frontend_enable_pin_o(rx_frontend_enable_pin_o),
   .rx_frontend_enable_pin_oe(rx_frontend_enable_pin_oe),
   .rf_port1_active(rf_port1_active), .rf_port2_active(rf_port2_active));
